// ### amc_pkg.sv
`default_nettype none
package amc_pkg;
   //------------------------------------------------------------
   // Register offsets
   //------------------------------------------------------------
   localparam logic [7:0] ADDR_MASK_ONE = 8'h74;
   localparam logic [7:0] ADDR_MASK_TWO = 8'h75;
   localparam logic [7:0] ADDR_VOLT_LOW = 8'h76;
   localparam logic [7:0] ADDR_TEMP_LOW = 8'h77;
   localparam logic [7:0] ADDR_CONFIG   = 8'h78;
   //------------------------------------------------------------
   // Reset values and field positions
   //------------------------------------------------------------
   localparam logic [7:0] RST_MASK    = 8'h00;
   localparam logic [7:0] RST_CONFIG  = 8'h00;
   localparam logic [7:0] MASK_ONE_WR = 8'hF6;
   localparam logic [7:0] MASK_TWO_WR = 8'hFC;
   localparam int BIT_GATE      = 7;
   localparam int BIT_OVT       = 1;
   localparam int BIT_FAN_FOUR  = 5;
   localparam int BIT_ALERT_EN  = 0;
   localparam int BIT_TIMER_EN  = 1;
   localparam int BIT_BOOST     = 2;
   localparam int BIT_FAST      = 3;
   localparam int BIT_DC_LO     = 4;
   localparam logic [1:0] PIN_FUNC_ALARM = 2'h1;
   // Status bits that own a mask bit; the rest never reach the alert
   localparam logic [7:0] ALERT_ONE_SRC = 8'h76;
   localparam logic [7:0] ALERT_TWO_SRC = 8'hFE;
   //------------------------------------------------------------
   // Timing
   //------------------------------------------------------------
   localparam int FAST_PERIOD_MS = 250;
   localparam int SLOW_PERIOD_MS = 1000;
   //------------------------------------------------------------
   // Register bus request and measurement carriers
   //------------------------------------------------------------
   typedef struct packed {
      logic       wrEn;
      logic       rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } amc_req_t;
   typedef struct packed {
      logic [1:0] procLow;
      logic [1:0] mainLow;
      logic [1:0] remOneLow;
      logic [1:0] localLow;
      logic [1:0] remTwoLow;
   } amc_low_t;
endpackage
`default_nettype wire

// ### amc_alert_mask_and_monitor_config.sv
`timescale 1ns/10ps
`default_nettype none
module amc_alert_mask_and_monitor_config #(
   parameter int CLK_HZ = 25000000   // System clock rate
) (
   input  wire logic             sys_clk,       // System clock
   input  wire logic             reset_n,       // Async reset, active low
   input  wire amc_pkg::amc_req_t busReq,       // Register access strobe and data
   input  wire logic             ovtMaskIn,     // Overtemperature mask from elsewhere
   input  wire logic [7:0]       statusOne,     // First status flags
   input  wire logic [7:0]       statusTwo,     // Second status flags
   input  wire amc_pkg::amc_low_t lowIn,        // Fresh low bits of readings
   input  wire logic             lockBit,       // Configuration lock
   input  wire logic [1:0]       shared_pin_function, // Alarm pin function select
   input  wire logic             thermal_alarm_pin,   // Alarm input, active high level
   input  wire logic             upperReadDone, // Upper-bit registers were read
   output logic [7:0]            rdData_ff,     // Read data
   output logic                  alertOut_n_ff, // Alert, active low
   output logic                  alertPinSel_ff,// Shared pin acts as alert
   output logic                  timerEn_ff,    // Alarm timer monitoring on
   output logic                  fanBoost_ff,   // All fans to max duty
   output logic                  measTick_ff,   // Speed measurement strobe
   output logic [3:0]            contSpeed_ff,  // Continuous measurement per channel
   output logic                  freeze_ff      // Upper-bit registers frozen
);
   //------------------------------------------------------------
   // Elaboration check and timing counts
   //------------------------------------------------------------
   localparam int FAST_CYC = CLK_HZ / 1000 * amc_pkg::FAST_PERIOD_MS;
   localparam int SLOW_CYC = CLK_HZ / 1000 * amc_pkg::SLOW_PERIOD_MS;
   // Below 1 kHz the millisecond periods round down to zero cycles
   if (CLK_HZ < 1000) begin : g_bad_clk
      $error("clock rate too low");
   end

   logic [7:0]  maskOne_ff;
   logic [7:0]  maskTwo_ff;
   logic [7:0]  config_ff;
   logic [7:0]  voltLow_ff;
   logic [7:0]  tempLow_ff;
   logic [31:0] tickCnt_ff;

   //------------------------------------------------------------
   // Decode
   //------------------------------------------------------------
   wire hitOne  = busReq.addr == amc_pkg::ADDR_MASK_ONE;
   wire hitTwo  = busReq.addr == amc_pkg::ADDR_MASK_TWO;
   wire hitVolt = busReq.addr == amc_pkg::ADDR_VOLT_LOW;
   wire hitTemp = busReq.addr == amc_pkg::ADDR_TEMP_LOW;
   wire hitCfg  = busReq.addr == amc_pkg::ADDR_CONFIG;
   wire cfgWr   = busReq.wrEn & hitCfg & ~lockBit;
   wire lowRd   = busReq.rdEn & (hitVolt | hitTemp);
   wire [7:0] maskTwoView = {maskTwo_ff[7:2], ovtMaskIn, maskTwo_ff[0]};

   // Read selection; unmapped addresses read zero
   logic [7:0] rdSel;
   always_comb begin
      if (hitOne) begin
         rdSel = maskOne_ff;
      end else if (hitTwo) begin
         rdSel = maskTwoView;
      end else if (hitVolt) begin
         rdSel = voltLow_ff;
      end else if (hitTemp) begin
         rdSel = tempLow_ff;
      end else if (hitCfg) begin
         rdSel = config_ff;
      end else begin
         rdSel = 8'h00;
      end
   end

   //------------------------------------------------------------
   // Alert gating
   //------------------------------------------------------------
   // Second-status events pass when unmasked; gate bit decides the all-masked case
   wire [7:0] liveOne  = statusOne & ~maskOne_ff & amc_pkg::ALERT_ONE_SRC;
   wire [7:0] liveTwo  = statusTwo & ~maskTwoView & amc_pkg::ALERT_TWO_SRC;
   wire       allTwoMasked = &maskTwoView[7:1];
   wire       gateTwo  = allTwoMasked & ~maskOne_ff[amc_pkg::BIT_GATE] & (|statusTwo[7:1]);
   wire       nxt_alert_n = ~((|liveOne) | (|liveTwo) | gateTwo);

   // Measurement period follows the fast bit
   wire [31:0] period = config_ff[amc_pkg::BIT_FAST] ? 32'(FAST_CYC) : 32'(SLOW_CYC);
   wire        tickHit = tickCnt_ff >= period - 32'h1;

   //------------------------------------------------------------
   // Mask and config registers
   //------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         maskOne_ff <= amc_pkg::RST_MASK;
         maskTwo_ff <= amc_pkg::RST_MASK;
         config_ff  <= amc_pkg::RST_CONFIG;
      end else begin
         if (busReq.wrEn & hitOne) maskOne_ff <= busReq.wrData & amc_pkg::MASK_ONE_WR;
         if (busReq.wrEn & hitTwo) maskTwo_ff <= busReq.wrData & amc_pkg::MASK_TWO_WR;
         if (cfgWr) config_ff <= busReq.wrData;
      end
   end

   //------------------------------------------------------------
   // Low-bit capture with freeze
   //------------------------------------------------------------
   // Freeze holds until the upper bytes are read, so both halves match
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         voltLow_ff <= 8'h00;
         tempLow_ff <= 8'h00;
         freeze_ff  <= 1'b0;
      end else begin
         if (lowRd) begin
            freeze_ff <= 1'b1;
         end else if (upperReadDone) begin
            freeze_ff <= 1'b0;
         end
         if (!freeze_ff && !lowRd) begin
            voltLow_ff <= {2'h0, lowIn.mainLow, lowIn.procLow, 2'h0};
            tempLow_ff <= {lowIn.remTwoLow, lowIn.localLow, lowIn.remOneLow, 2'h0};
         end
      end
   end

   //------------------------------------------------------------
   // Outputs and measurement timer
   //------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdData_ff      <= 8'h00;
         alertOut_n_ff  <= 1'b1;
         alertPinSel_ff <= 1'b0;
         timerEn_ff     <= 1'b0;
         fanBoost_ff    <= 1'b0;
         measTick_ff    <= 1'b0;
         contSpeed_ff   <= 4'h0;
         tickCnt_ff     <= 32'h0;
      end else begin
         rdData_ff      <= busReq.rdEn ? rdSel : rdData_ff;
         alertOut_n_ff  <= nxt_alert_n;
         alertPinSel_ff <= config_ff[amc_pkg::BIT_ALERT_EN];
         timerEn_ff     <= config_ff[amc_pkg::BIT_TIMER_EN]
                           & (shared_pin_function == amc_pkg::PIN_FUNC_ALARM);
         fanBoost_ff    <= config_ff[amc_pkg::BIT_BOOST] & thermal_alarm_pin
                           & (shared_pin_function == amc_pkg::PIN_FUNC_ALARM);
         contSpeed_ff   <= config_ff[amc_pkg::BIT_DC_LO +: 4];
         measTick_ff    <= tickHit;
         tickCnt_ff     <= tickHit ? 32'h0 : tickCnt_ff + 32'h1;
      end
   end
endmodule
`default_nettype wire

// ### amc_chk.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level watch on the mask and config block
module amc_chk (
   input wire logic              sys_clk,           // Clock
   input wire logic              reset_n,           // Reset
   input wire amc_pkg::amc_req_t busReq,            // Request
   input wire logic              ovtMaskIn,         // Mask source
   input wire logic [7:0]        statusOne,         // Flags one
   input wire logic [7:0]        statusTwo,         // Flags two
   input wire logic              lockBit,           // Lock
   input wire logic              thermal_alarm_pin, // Alarm
   input wire logic              upperReadDone,     // Release
   input wire logic [7:0]        rdData_ff,         // Read data
   input wire logic              alertOut_n_ff,     // Alert
   input wire logic              alertPinSel_ff,    // Pin select
   input wire logic              fanBoost_ff,       // Boost
   input wire logic              measTick_ff,       // Tick
   input wire logic              freeze_ff          // Frozen
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Freeze must span the gap between the low read and the upper read
   frz_set_a: assert property (busReq.rdEn && busReq.addr[7:1] == 7'h3B |=> freeze_ff)
      else $error("freeze not set");
   frz_hold_a: assert property (freeze_ff && !upperReadDone |=> freeze_ff)
      else $error("freeze lost early");
   frz_drop_a: assert property (upperReadDone && !busReq.rdEn |=> !freeze_ff)
      else $error("freeze not released");
   ovt_read_a: assert property (busReq.rdEn && busReq.addr == 8'h75 |=> rdData_ff[1] == $past(ovtMaskIn))
      else $error("overtemp mask readback");
   idle_alert_a: assert property (statusOne == 8'h00 && statusTwo == 8'h00 |=> alertOut_n_ff)
      else $error("alert without flag");
   boost_cause_a: assert property (!thermal_alarm_pin |=> !fanBoost_ff)
      else $error("boost without alarm");
   lock_keep_a: assert property (lockBit && busReq.wrEn && busReq.addr == 8'h78 |=> $stable(alertPinSel_ff))
      else $error("locked config changed");
   tick_pulse_a: assert property (measTick_ff |=> !measTick_ff [*2])
      else $error("tick too wide");
endmodule
`default_nettype wire

// ### amc_host.sv
`timescale 1ns/10ps
`default_nettype none
// Host side: one-cycle strobes, data taken after the answering edge
module amc_host (
   input  wire logic            sys_clk, // Clock
   input  wire logic [7:0]      rdData,  // Read data
   output var amc_pkg::amc_req_t busReq  // Request
);
   logic [7:0] rdVal;
   initial busReq = '0;
   // Held through the taking edge, released only after it
   task automatic access(input logic wr, input logic [7:0] a, d);
      @(posedge sys_clk) #1;
      busReq = '{wrEn: wr, rdEn: !wr, addr: a, wrData: d};
      @(posedge sys_clk) #1;
      rdVal = rdData;
      busReq = '0;
   endtask
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic              sys_clk, reset_n, ovtMask, lockBit, alarm, upDone;
   logic              alertN, pinSel, timerEn, boost, tick, freeze;
   logic [7:0]        stOne, stTwo, rdData;
   logic [1:0]        pinFunc;
   logic [3:0]        contSpeed;
   amc_pkg::amc_req_t busReq;
   amc_pkg::amc_low_t lowIn;
   int                err_total, comparisons;
   // Small clock rate keeps the tick periods at 1000 and 4000 cycles
   amc_alert_mask_and_monitor_config #(.CLK_HZ(4000)) dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .busReq(busReq), .ovtMaskIn(ovtMask),
      .statusOne(stOne), .statusTwo(stTwo), .lowIn(lowIn), .lockBit(lockBit),
      .shared_pin_function(pinFunc), .thermal_alarm_pin(alarm), .upperReadDone(upDone),
      .rdData_ff(rdData), .alertOut_n_ff(alertN), .alertPinSel_ff(pinSel),
      .timerEn_ff(timerEn), .fanBoost_ff(boost), .measTick_ff(tick),
      .contSpeed_ff(contSpeed), .freeze_ff(freeze));
   amc_host host (.sys_clk(sys_clk), .rdData(rdData), .busReq(busReq));
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   task automatic chk(input string n, input logic [15:0] e, g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // Two edges: register update, then the registered output
   task automatic settle;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e, input string n);
      host.access(1'b0, a, 8'h00);
      chk(n, e, {8'h00, host.rdVal});
   endtask
   task automatic gap(input logic [15:0] e);
      int n;
      for (n = 0; tick !== 1'b1 && n < 9000; n++) @(posedge sys_clk) #1;
      @(posedge sys_clk) #1;
      for (n = 1; tick !== 1'b1 && n < 9000; n++) @(posedge sys_clk) #1;
      chk("tick gap", e, n[15:0]);
      if (n >= 9000) print_verdict;
   endtask
   task automatic print_verdict;
      if (err_total == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   //------------------------------------------------------------
   // Scenarios
   //------------------------------------------------------------
   task automatic t_reset;
      rd(8'h74, 16'h0000, "mask one");
      rd(8'h75, 16'h0000, "mask two");
      rd(8'h79, 16'h0000, "unmapped");
   endtask
   // Each writable mask bit except gate bit 7 against its own flag; bit 8 up is mask two
   task automatic t_masks;
      for (int i = 1; i < 16; i++) begin
         if (i == 3 || i == 7 || i == 8 || i == 9) continue;
         {stTwo, stOne} = 16'h0001 << i;
         host.access(1'b1, i < 8 ? 8'h74 : 8'h75, 8'h01 << i[2:0]);
         settle;
         chk("alert masked", 16'h0001, 16'(alertN));
         host.access(1'b1, i < 8 ? 8'h74 : 8'h75, 8'h00);
         settle;
         chk("alert open", 16'h0000, 16'(alertN));
      end
      ovtMask = 1'b1;
      host.access(1'b1, 8'h75, 8'hFF);
      rd(8'h75, 16'h00FE, "mask two bits");
      {stTwo, stOne} = 16'h0200;
      settle;
      chk("gate open", 16'h0000, 16'(alertN));
      host.access(1'b1, 8'h74, 8'hFF);
      rd(8'h74, 16'h00F6, "mask one bits");
      settle;
      chk("gate shut", 16'h0001, 16'(alertN));
      ovtMask = 1'b0;
      settle;
      chk("overtemp open", 16'h0000, 16'(alertN));
      stTwo = 8'h00;
   endtask
   task automatic t_low;
      lowIn = 10'h180;
      settle;
      rd(8'h76, 16'h0024, "volt low");
      chk("frozen", 16'h0001, 16'(freeze));
      lowIn = 10'h036;
      settle;
      rd(8'h76, 16'h0024, "volt held");
      upDone = 1'b1;
      @(posedge sys_clk) #1;
      upDone = 1'b0;
      settle;
      chk("released", 16'h0000, 16'(freeze));
      rd(8'h77, 16'h009C, "temp low");
   endtask
   task automatic t_config;
      pinFunc = 2'h1;
      alarm = 1'b1;
      host.access(1'b1, 8'h78, 8'hFF);
      settle;
      chk("config out", 16'h007F, {9'h000, pinSel, timerEn, boost, contSpeed});
      gap(16'h03E8);
      lockBit = 1'b1;
      host.access(1'b1, 8'h78, 8'h00);
      rd(8'h78, 16'h00FF, "locked");
      lockBit = 1'b0;
      host.access(1'b1, 8'h78, 8'h00);
      settle;
      chk("config off", 16'h0000, {9'h000, pinSel, timerEn, boost, contSpeed});
      gap(16'h0FA0);
   endtask
   // Reset held two cycles, inputs set at time zero
   initial begin
      {reset_n, ovtMask, lockBit, alarm, upDone} = 5'h00;
      {stOne, stTwo, pinFunc} = 18'h00000;
      lowIn = 10'h000;
      err_total = 0;
      comparisons = 0;
      repeat (2) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      t_reset;
      t_masks;
      t_low;
      t_config;
      print_verdict;
   end
endmodule
bind amc_alert_mask_and_monitor_config amc_chk chk_i (
   .sys_clk(sys_clk), .reset_n(reset_n), .busReq(busReq), .ovtMaskIn(ovtMaskIn),
   .statusOne(statusOne), .statusTwo(statusTwo), .lockBit(lockBit),
   .thermal_alarm_pin(thermal_alarm_pin), .upperReadDone(upperReadDone),
   .rdData_ff(rdData_ff), .alertOut_n_ff(alertOut_n_ff), .alertPinSel_ff(alertPinSel_ff),
   .fanBoost_ff(fanBoost_ff), .measTick_ff(measTick_ff), .freeze_ff(freeze_ff));
`default_nettype wire
